/* File: logic/mirc_pkg.sv */
// constants shared by the interrupt request control block
package mirc_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_EXT0_CTL = 8'h00;
  localparam logic [7:0] OFF_EXT1_CTL = 8'h04;
  localparam logic [7:0] OFF_SRC_SEL = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN1 = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN2 = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTL_RISE_BIT = 1;
  localparam int CTL_BOTH_BIT = 2;
  localparam int CTL_GATE_BIT = 3;
  localparam int EN1_EXT0_BIT = 0;
  localparam int EN1_EXT1_BIT = 1;
  localparam int EN2_T3_BIT = 0;
  localparam int EN2_SHARED_BIT = 3;
  localparam int STAT_INTE_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam logic SEL_TIMER4 = 1'h0;
  localparam logic SEL_SERIAL = 1'h1;

  // ------------------------------------------------------------
  // source indices, also the flag bit order
  // ------------------------------------------------------------
  localparam logic [1:0] SRC_EXT0 = 2'h0;
  localparam logic [1:0] SRC_EXT1 = 2'h1;
  localparam logic [1:0] SRC_TIMER3 = 2'h2;
  localparam logic [1:0] SRC_SHARED = 2'h3;

  // ------------------------------------------------------------
  // reset values and timing
  // ------------------------------------------------------------
  localparam logic [3:0] RST_CTL = 4'h0;
  localparam logic [3:0] RST_EN = 4'h0;
  localparam logic RST_SEL = 1'h0;
  localparam int FILT_CYC = 4;

endpackage

/* File: logic/mirc_ext_edge.sv */
// valid-waveform filter and edge detector for one external input
module mirc_ext_edge #(
  parameter int FILT_CYC = mirc_pkg::FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  input wire logic gate_i,
  input wire logic rise_i,
  input wire logic both_i,
  output logic event_o
);

  localparam int CW = $clog2(FILT_CYC + 1);

  // the counter needs at least two states to tell a glitch from a level
  if (FILT_CYC < 2)
  begin : g_bad_filt
    $error("filter length below two cycles");
  end

  typedef struct packed {
    logic filt;
    logic [CW-1:0] cnt;
  } mirc_edge_st_t;

  mirc_edge_st_t st_q, st_d;
  logic gated;

  // gate forced low keeps the detector quiet; toggling the gate with
  // the pin high therefore looks like an edge and may raise the flag
  assign gated = gate_i & pin_i; // RQ2 RQ4

  always_comb
  begin
    st_d = st_q;
    if (gated != st_q.filt)
    begin
      if (st_q.cnt == CW'(FILT_CYC - 1))
      begin
        st_d.filt = gated; // RQ19
        st_d.cnt = '0;
      end
      else
        st_d.cnt = st_q.cnt + CW'(1);
    end
    else
      st_d.cnt = '0;
    event_o = (st_d.filt != st_q.filt) &&
              (both_i || (st_d.filt == rise_i)); // RQ18
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_FILTER_HOLD: assert property ( // RQ19
    @(posedge clk_i) disable iff (rst_i)
    $changed(st_q.filt) |-> $past(gated, 1) == st_q.filt &&
      $past(gated, 2) == st_q.filt && $past(gated, 3) == st_q.filt &&
      $past(gated, 4) == st_q.filt)
    else $error("filtered level changed before four stable cycles");

endmodule

/* File: logic/mirc_irq_ctrl.sv */
// interrupt request control: pins, flags, enables, dispatch, skip tests
// ------------------------------------------------------------
// Function
// (RQ1) ext0 edge-mode write may raise flag
// (RQ2) ext0 gate write may raise flag
// (RQ3) ext1 edge-mode write may raise flag
// (RQ4) ext1 gate write may raise flag
// (RQ5) no nesting while a service routine runs
// (RQ6) dispatch clears master enable at once
// (RQ7) enable then return re-arms at return
// (RQ8) ext0 gating leaves port bit 8 driver working
// (RQ9) valid ext0 waveform sets flag even when output
// (RQ10) ext1 gating leaves port bit 9 driver working
// (RQ11) valid ext1 waveform sets flag even when output
// (RQ12) enable2 bit3 gates shared timer4/serial request
// (RQ13) enable2 bit0 gates timer3 request
// (RQ14) skip test clears set flag and skips
// (RQ15) select register picks shared request source
// (RQ16) select 0 timer4, 1 serial
// (RQ17) enabled source makes its skip test a no-op
// (RQ18) edge: falling, rising or both
// (RQ19) pin level must hold four clocks
// (RQ20) dispatch needs master, source enable and flag
// (RQ21) flags persist while source disabled
module mirc_irq_ctrl #(
  parameter int FILT_CYC = mirc_pkg::FILT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext0_input_i,
  input wire logic ext1_input_i,
  input wire logic port_bit8_data_i,
  input wire logic port_bit8_drive_i,
  input wire logic port_bit9_data_i,
  input wire logic port_bit9_drive_i,
  output logic port_bit8_o,
  output logic port_bit8_oe_n_o,
  output logic port_bit9_o,
  output logic port_bit9_oe_n_o,
  input wire logic timer3_event_i,
  input wire logic timer4_event_i,
  input wire logic serial_event_i,
  input wire logic enable_irq_instr_i,
  input wire logic disable_irq_instr_i,
  input wire logic return_from_irq_instr_i,
  input wire logic [3:0] skip_test_i,
  output logic skip_o,
  output logic irq_take_o,
  output logic [1:0] irq_source_o,
  output logic inte_o
);

  typedef struct packed {
    logic [3:0] ctl0;
    logic [3:0] ctl1;
    logic sel;
    logic [3:0] en1;
    logic [3:0] en2;
    logic [3:0] flag;
    logic inte;
    logic busy;
    logic take;
    logic [1:0] src;
    logic [1:0] pout;
    logic [1:0] poe_n;
    logic ack;
    logic [31:0] rdat;
  } mirc_st_t;

  mirc_st_t st_q, st_d;
  logic ev0, ev1;
  logic [3:0] ev, en, ready, clr, skip_hit;
  logic [1:0] pick_src;
  logic dispatch, wb_req;

  // lowest index wins; ext0 has the highest priority
  function automatic logic [1:0] pick(input logic [3:0] req);
    logic [1:0] r;
    r = mirc_pkg::SRC_SHARED;
    for (int i = 3; i >= 0; i--)
      if (req[i])
        r = 2'(i);
    return r;
  endfunction

  // ------------------------------------------------------------
  // external inputs
  // ------------------------------------------------------------
  // the detectors see the pad level whatever the port driver does
  mirc_ext_edge #(.FILT_CYC(FILT_CYC)) u_edge0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext0_input_i),
    .gate_i(st_q.ctl0[mirc_pkg::CTL_GATE_BIT]),
    .rise_i(st_q.ctl0[mirc_pkg::CTL_RISE_BIT]),
    .both_i(st_q.ctl0[mirc_pkg::CTL_BOTH_BIT]),
    .event_o(ev0)
  );

  mirc_ext_edge #(.FILT_CYC(FILT_CYC)) u_edge1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext1_input_i),
    .gate_i(st_q.ctl1[mirc_pkg::CTL_GATE_BIT]),
    .rise_i(st_q.ctl1[mirc_pkg::CTL_RISE_BIT]),
    .both_i(st_q.ctl1[mirc_pkg::CTL_BOTH_BIT]),
    .event_o(ev1)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    st_d.take = 1'b0;
    // port drivers ignore the interrupt gating entirely
    st_d.pout = {port_bit9_data_i, port_bit8_data_i}; // RQ8 RQ10
    st_d.poe_n = ~{port_bit9_drive_i, port_bit8_drive_i}; // RQ8 RQ10

    ev[mirc_pkg::SRC_EXT0] = ev0; // RQ9 RQ1 RQ2
    ev[mirc_pkg::SRC_EXT1] = ev1; // RQ11 RQ3 RQ4
    ev[mirc_pkg::SRC_TIMER3] = timer3_event_i;
    ev[mirc_pkg::SRC_SHARED] = (st_q.sel == mirc_pkg::SEL_SERIAL) ?
      serial_event_i : timer4_event_i; // RQ15 RQ16

    en[mirc_pkg::SRC_EXT0] = st_q.en1[mirc_pkg::EN1_EXT0_BIT];
    en[mirc_pkg::SRC_EXT1] = st_q.en1[mirc_pkg::EN1_EXT1_BIT];
    en[mirc_pkg::SRC_TIMER3] = st_q.en2[mirc_pkg::EN2_T3_BIT]; // RQ13
    en[mirc_pkg::SRC_SHARED] = st_q.en2[mirc_pkg::EN2_SHARED_BIT]; // RQ12

    // skip test is a no-op for an enabled source
    skip_hit = skip_test_i & st_q.flag & ~en; // RQ14 RQ17
    skip_o = |skip_hit; // RQ14

    ready = st_q.flag & en; // RQ20
    pick_src = pick(ready);
    dispatch = st_q.inte && !st_q.busy && (|ready); // RQ5 RQ20
    clr = '0;

    if (enable_irq_instr_i)
      st_d.inte = 1'b1;
    if (disable_irq_instr_i)
      st_d.inte = 1'b0;
    // enable stays masked by busy until the return: no early nesting
    if (return_from_irq_instr_i)
      st_d.busy = 1'b0; // RQ7
    if (dispatch)
    begin
      st_d.take = 1'b1;
      st_d.src = pick_src;
      st_d.inte = 1'b0; // RQ6
      st_d.busy = 1'b1; // RQ5
      clr[pick_src] = 1'b1; // RQ20
    end
    // a new event wins over any clear in the same cycle
    st_d.flag = (st_q.flag & ~clr & ~skip_hit) | ev; // RQ21

    // register bus: one wait state, ack drops the cycle after
    wb_req = wb_cyc_i && wb_stb_i && !st_q.ack;
    st_d.ack = wb_req;
    st_d.rdat = '0;
    if (wb_req && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        mirc_pkg::OFF_EXT0_CTL: st_d.ctl0 = wb_dat_i[3:0];
        mirc_pkg::OFF_EXT1_CTL: st_d.ctl1 = wb_dat_i[3:0];
        mirc_pkg::OFF_SRC_SEL: st_d.sel = wb_dat_i[0]; // RQ15
        mirc_pkg::OFF_IRQ_EN1: st_d.en1 = wb_dat_i[3:0];
        mirc_pkg::OFF_IRQ_EN2: st_d.en2 = wb_dat_i[3:0]; // RQ12 RQ13
        default: st_d.rdat = '0;
      endcase
    end
    if (wb_req && !wb_we_i)
    begin
      case (wb_adr_i)
        mirc_pkg::OFF_EXT0_CTL: st_d.rdat[3:0] = st_q.ctl0;
        mirc_pkg::OFF_EXT1_CTL: st_d.rdat[3:0] = st_q.ctl1;
        mirc_pkg::OFF_SRC_SEL: st_d.rdat[0] = st_q.sel;
        mirc_pkg::OFF_IRQ_EN1: st_d.rdat[3:0] = st_q.en1;
        mirc_pkg::OFF_IRQ_EN2: st_d.rdat[3:0] = st_q.en2;
        mirc_pkg::OFF_STATUS:
        begin
          st_d.rdat[3:0] = st_q.flag;
          st_d.rdat[mirc_pkg::STAT_INTE_BIT] = st_q.inte;
          st_d.rdat[mirc_pkg::STAT_BUSY_BIT] = st_q.busy;
        end
        default: st_d.rdat = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= '0;
      st_q.ctl0 <= mirc_pkg::RST_CTL;
      st_q.ctl1 <= mirc_pkg::RST_CTL;
      st_q.sel <= mirc_pkg::RST_SEL;
      st_q.en1 <= mirc_pkg::RST_EN;
      st_q.en2 <= mirc_pkg::RST_EN;
      st_q.poe_n <= 2'h3;
    end
    else
      st_q <= st_d;
  end

  assign wb_dat_o = st_q.rdat;
  assign wb_ack_o = st_q.ack;
  assign port_bit8_o = st_q.pout[0];
  assign port_bit9_o = st_q.pout[1];
  assign port_bit8_oe_n_o = st_q.poe_n[0];
  assign port_bit9_oe_n_o = st_q.poe_n[1];
  assign irq_take_o = st_q.take;
  assign irq_source_o = st_q.src;
  assign inte_o = st_q.inte;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_taken;
    irq_take_o;
  endsequence

  sequence s_serviced;
    st_q.busy && !return_from_irq_instr_i;
  endsequence

  // enable issued in service, return on the very next cycle
  sequence s_ei_then_rti;
    st_q.busy && enable_irq_instr_i ##1 return_from_irq_instr_i;
  endsequence

  AST_TAKE_CLEARS_INTE: assert property (s_taken |-> !st_q.inte) // RQ6
    else $error("master enable still set after dispatch");

  AST_NO_NESTING: assert property (s_serviced |=> !irq_take_o) // RQ5
    else $error("second dispatch while in service");

  // index the sampled vectors by the source shown now, not the old one
  AST_TAKE_GATED: assert property (s_taken |-> $past(st_q.inte) && // RQ20
    (($past(ready) >> irq_source_o) & 4'h1) == 4'h1 &&
    (!st_q.flag[irq_source_o] ||
    (($past(ev) >> irq_source_o) & 4'h1) == 4'h1))
    else $error("dispatch without enable and flag");

  AST_EI_AT_RETURN: assert property (s_ei_then_rti |=> // RQ7
    st_q.inte && !st_q.busy)
    else $error("enable not armed at return");

  AST_SKIP_CLEARS: assert property (skip_o && ev == 4'h0 |=> // RQ14
    (st_q.flag & $past(skip_hit)) == 4'h0)
    else $error("skip test did not clear its flag");

  AST_SKIP_NOP: assert property ( // RQ17
    (skip_test_i & en) == skip_test_i |-> !skip_o)
    else $error("skip test acted on an enabled source");

  AST_FLAG_KEPT: assert property ( // RQ21
    st_q.flag[mirc_pkg::SRC_EXT0] && !en[mirc_pkg::SRC_EXT0] &&
    !skip_test_i[mirc_pkg::SRC_EXT0] |=> st_q.flag[mirc_pkg::SRC_EXT0])
    else $error("disabled flag lost");

  AST_EXT0_SETS: assert property ( // RQ9
    ev0 |=> st_q.flag[mirc_pkg::SRC_EXT0])
    else $error("ext0 waveform did not set its flag");

  AST_EXT1_SETS: assert property ( // RQ11
    ev1 |=> st_q.flag[mirc_pkg::SRC_EXT1])
    else $error("ext1 waveform did not set its flag");

  AST_SHARED_SEL: assert property ( // RQ16
    st_q.sel == mirc_pkg::SEL_TIMER4 && serial_event_i &&
    !timer4_event_i && !st_q.flag[mirc_pkg::SRC_SHARED] |=>
    !st_q.flag[mirc_pkg::SRC_SHARED])
    else $error("unselected shared source raised the flag");

  AST_T3_GATED: assert property ( // RQ13
    !st_q.en2[mirc_pkg::EN2_T3_BIT] |=>
    !(irq_take_o && irq_source_o == mirc_pkg::SRC_TIMER3))
    else $error("timer3 dispatched while disabled");

  AST_SHARED_GATED: assert property ( // RQ12
    !st_q.en2[mirc_pkg::EN2_SHARED_BIT] |=>
    !(irq_take_o && irq_source_o == mirc_pkg::SRC_SHARED))
    else $error("shared source dispatched while disabled");

  AST_PORT_DRIVE: assert property ( // RQ8
    ##1 port_bit8_oe_n_o == !$past(port_bit8_drive_i) &&
    port_bit8_o == $past(port_bit8_data_i))
    else $error("port bit 8 driver disturbed");

endmodule

/* File: test/mirc_seq_model.sv */
// core sequencer model: runs a service routine, then re-arms and returns
module mirc_seq_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic take_i,
  input wire logic slow_i,
  output logic ei_o,
  output logic rti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // ----
  // routine length
  // ----
  // a slow body keeps busy up long enough for a second request to wait
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= 4'h0;
    end
    else if (take_i)
    begin
      cnt_q <= slow_i ? 4'hC : 4'h3;
    end
    else if (cnt_q != 4'h0)
    begin
      cnt_q <= cnt_q - 4'h1;
    end
  end
  // enable right before the return, so the return re-arms
  assign ei_o = (cnt_q == 4'h2);
  assign rti_o = (cnt_q == 4'h1);
endmodule

/* File: test/mirc_irq_ctrl_tb.sv */
// self-checking testbench for the interrupt request control block
module mirc_irq_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, ack, e0, e1, d8, dr8, d9, dr9;
  logic o8, oe8, o9, oe9, t3, t4, si, ei, ei_tb, ei_m, di, return_from_irq_instr;
  logic skip, take, inte, slow;
  logic [7:0] adr;
  logic [31:0] wd, rdat, q;
  logic [3:0] sk_v;
  logic [1:0] src;
  int n_mismatch, compares, cyc_cnt, n_take;
  assign ei = ei_tb | ei_m;
  mirc_irq_ctrl i_mirc_irq_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext0_input_i(e0), .ext1_input_i(e1), .port_bit8_data_i(d8),
    .port_bit8_drive_i(dr8), .port_bit9_data_i(d9),
    .port_bit9_drive_i(dr9), .port_bit8_o(o8), .port_bit8_oe_n_o(oe8),
    .port_bit9_o(o9), .port_bit9_oe_n_o(oe9), .timer3_event_i(t3),
    .timer4_event_i(t4), .serial_event_i(si), .enable_irq_instr_i(ei),
    .disable_irq_instr_i(di), .return_from_irq_instr_i(return_from_irq_instr),
    .skip_test_i(sk_v), .skip_o(skip), .irq_take_o(take),
    .irq_source_o(src), .inte_o(inte));
  mirc_seq_model i_mirc_seq_model (.clk_i(clk_i), .rst_i(rst_i),
    .take_i(take), .slow_i(slow), .ei_o(ei_m), .rti_o(return_from_irq_instr));
  initial
  begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // ----
  // shared tasks
  // ----
  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0)
    begin
      $display("Simulation passed");
    end
    else
    begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= d;
    @(posedge clk_i);
    // ack ends this wait; if ack never comes, only the bench timeout ends it
    while (ack !== 1'h1)
    begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n), 32'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
    chk(32'(ack), 32'h0);
  endtask
  task automatic st(input logic [31:0] e);
    wb(1'h0, mirc_pkg::OFF_STATUS, 32'h0);
    chk(q & 32'hF, e);
  endtask
  task automatic sk(input logic [3:0] m, input logic [31:0] e);
    sk_v <= m;
    @(negedge clk_i);
    chk(32'(skip), e);
    @(posedge clk_i);
    sk_v <= 4'h0;
    @(posedge clk_i);
  endtask
  task automatic px(input int w, input logic v, input int c);
    if (w == 0) e0 <= v;
    else e1 <= v;
    repeat (c) @(posedge clk_i);
  endtask
  task automatic ev(input int k);
    t3 <= (k == 0);
    t4 <= (k == 1);
    si <= (k == 2);
    @(posedge clk_i);
    {t3, t4, si} <= 3'h0;
    @(posedge clk_i);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset();
    st(32'h0);
    chk(32'(oe8), 32'h1);
    chk(32'(inte), 32'h0);
    wb(1'h1, mirc_pkg::OFF_IRQ_EN1, 32'h0F);
    wb(1'h0, mirc_pkg::OFF_IRQ_EN1, 32'h0);
    chk(q, 32'h0F);
    wb(1'h1, mirc_pkg::OFF_IRQ_EN1, 32'h0);
    wb(1'h0, 8'hFC, 32'h0);
    chk(q, 32'h0);
  endtask
  task automatic t_ext0();
    wb(1'h1, mirc_pkg::OFF_EXT0_CTL, 32'h0A);
    d8 <= 1'h1;
    dr8 <= 1'h1;
    px(0, 1'h1, 3);
    px(0, 1'h0, 6);
    st(32'h0);
    px(0, 1'h1, 6);
    st(32'h1);
    chk(32'({o8, oe8}), 32'h2);
    sk(4'h1, 32'h1);
    st(32'h0);
    wb(1'h1, mirc_pkg::OFF_EXT0_CTL, 32'h02);
    // let the filtered level fall before the gate comes back
    repeat (4) @(posedge clk_i);
    wb(1'h1, mirc_pkg::OFF_EXT0_CTL, 32'h0A);
    repeat (4) @(posedge clk_i);
    st(32'h1);
    wb(1'h1, mirc_pkg::OFF_IRQ_EN1, 32'h01);
    sk(4'h1, 32'h0);
    st(32'h1);
    wb(1'h1, mirc_pkg::OFF_IRQ_EN1, 32'h0);
    sk(4'h1, 32'h1);
    px(0, 1'h0, 6);
    wb(1'h1, mirc_pkg::OFF_EXT0_CTL, 32'h0E);
    st(32'h0);
  endtask
  task automatic t_ext1();
    wb(1'h1, mirc_pkg::OFF_EXT1_CTL, 32'h08);
    dr9 <= 1'h1;
    px(1, 1'h1, 6);
    st(32'h0);
    px(1, 1'h0, 6);
    st(32'h2);
    chk(32'({o9, oe9}), 32'h0);
    sk(4'h2, 32'h1);
    wb(1'h1, mirc_pkg::OFF_EXT1_CTL, 32'h0C);
    st(32'h0);
    px(1, 1'h1, 6);
    st(32'h2);
    sk(4'h2, 32'h1);
  endtask
  task automatic t_shared();
    for (int s = 0; s < 2; s++)
    begin
      wb(1'h1, mirc_pkg::OFF_SRC_SEL, 32'(s));
      ev(s == 0 ? 2 : 1);
      st(32'h0);
      ev(s == 0 ? 1 : 2);
      st(32'h8);
      sk(4'h8, 32'h1);
    end
  endtask
  task automatic t_disp();
    wb(1'h1, mirc_pkg::OFF_SRC_SEL, 32'h0);
    ev(1);
    slow <= 1'h1;
    ei_tb <= 1'h1;
    @(posedge clk_i);
    ei_tb <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk(32'(inte), 32'h1);
    chk(32'(n_take), 32'h0);
    wb(1'h1, mirc_pkg::OFF_IRQ_EN2, 32'h09);
    repeat (2) @(posedge clk_i);
    chk(32'(n_take), 32'h1);
    chk(32'(src), 32'h3);
    chk(32'(inte), 32'h0);
    ev(0);
    slow <= 1'h0;
    repeat (5) @(posedge clk_i);
    chk(32'(n_take), 32'h1);
    repeat (20) @(posedge clk_i);
    chk(32'(n_take), 32'h2);
    chk(32'(src), 32'h2);
    st(32'h0);
    chk(32'(inte), 32'h1);
    wb(1'h1, mirc_pkg::OFF_IRQ_EN2, 32'h0);
    di <= 1'h1;
    @(posedge clk_i);
    di <= 1'h0;
    @(posedge clk_i);
    chk(32'(inte), 32'h0);
  endtask
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (take === 1'h1) n_take++;
    if (cyc_cnt == 5000)
    begin
      n_mismatch++;
      stop_test();
    end
  end
  initial
  begin
    {cyc, stb, we, e0, e1, d8, dr8, d9, dr9, t3, t4, si} = 12'h0;
    {ei_tb, di, slow} = 3'h0;
    adr = 8'h0;
    wd = 32'h0;
    sk_v = 4'h0;
    n_mismatch = 0;
    compares = 0;
    cyc_cnt = 0;
    n_take = 0;
    rst_i = 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    t_reset();
    t_ext0();
    t_ext1();
    t_shared();
    t_disp();
    stop_test();
  end
endmodule
